// [rtl/edgtmr_pkg.sv]
// package of register map, field positions and constants for the edge timer
package edgtmr_pkg;
	// ==========================================================
	// register indices (8-bit registers on a plain port)
	localparam logic [3:0] ADDR_CTRL0 = 4'h0;
	localparam logic [3:0] ADDR_CTRL1 = 4'h1;
	localparam logic [3:0] ADDR_LIVE_LOW = 4'h2;
	localparam logic [3:0] ADDR_LIVE_HIGH = 4'h3;
	localparam logic [3:0] ADDR_CMP_LOW = 4'h4;
	localparam logic [3:0] ADDR_CMP_HIGH = 4'h5;
	localparam logic [3:0] ADDR_CAP_LOW = 4'h6;
	localparam logic [3:0] ADDR_CAP_HIGH = 4'h7;
	localparam logic [3:0] ADDR_INT_STATUS = 4'h8;
	localparam logic [3:0] ADDR_INT_MASK = 4'h9;
	// ==========================================================
	// control 0 field positions
	localparam int C0_PAUSE = 7;
	localparam int C0_CLK_HI = 6;
	localparam int C0_CLK_LO = 4;
	localparam int C0_ON = 3;
	localparam int C0_SRC_HI = 1;
	localparam int C0_SRC_LO = 0;
	localparam logic [7:0] C0_WMASK = 8'hfb;
	// control 1 field positions
	localparam int C1_EDGE_HI = 7;
	localparam int C1_EDGE_LO = 6;
	localparam int C1_TRIG_EN = 5;
	localparam int C1_NF_CNT = 4;
	localparam int C1_NF_CLK = 3;
	localparam int C1_NF_EN = 2;
	localparam int C1_CLR_LATCH = 1;
	localparam int C1_CLR_MATCH = 0;
	// interrupt status bits
	localparam int IRQ_OVF = 0;
	localparam int IRQ_MATCH = 1;
	localparam int IRQ_CAPT = 2;
	localparam int IRQ_BITS = 3;
	// ==========================================================
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [15:0] RESET_WORD = 16'h0000;
	localparam logic [1:0] NF_DIV = 2'h3;
	localparam logic [1:0] EDGE_OFF = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
	localparam logic [1:0] SRC_RESERVED = 2'h3;
	localparam logic [2:0] CLK_PWM = 3'h0;
endpackage : edgtmr_pkg

// [rtl/edgtmr_core.sv]
// 16-bit capture/compare edge timer with register port and interrupt
`timescale 1ns/1ps
// ==========================================================
// Summary of operation
// - compare value in two rw bytes, reset zero
// - captured count in two read-only bytes
// - three sensor sources, rise/fall/both edges
// - timer_on gates all counting
// - trigger_input_enable gates capture triggers
// - filter needs 2 or 4 equal samples
// - valid edge copies counter to capture
// - overflow sets overflow flag
// - clear_on_latch zeroes counter after capture
// - counter equal compare sets match flag
// - clear_on_match zeroes counter on match
// - match drives stall output for pwm shutdown
// - clock select: pwm tick or sys/2..128
// - timer_on rise clears counter, fall keeps
// - edge field 00 off,01 rise,10 fall,11 both
// - source 00 a,01 b,10 c,11 reserved
module edgtmr_core (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic [3:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [7:0] rdata_out,
	input wire logic sensor_input_a_in,
	input wire logic sensor_input_b_in,
	input wire logic sensor_input_c_in,
	input wire logic pwm_period_tick_in,
	output logic irq_out,
	output logic stall_out
);
	// ==========================================================
	// register file
	logic [7:0] ctrl0, next_ctrl0, ctrl1, next_ctrl1;
	logic [15:0] cmp, next_cmp, cap, next_cap, cnt, next_cnt;
	logic [2:0] status, next_status, mask, next_mask;
	logic [7:0] rdata, next_rdata;
	logic on_d, next_on_d;
	logic [6:0] pre, next_pre;
	logic [1:0] nf_div, next_nf_div;
	logic [3:0] hist, next_hist;
	logic filt, next_filt, prev_in, next_prev_in;
	logic stall, next_stall;

	wire logic timer_on = ctrl0[edgtmr_pkg::C0_ON];
	wire logic count_pause = ctrl0[edgtmr_pkg::C0_PAUSE];
	wire logic [2:0] count_clock_select = ctrl0[edgtmr_pkg::C0_CLK_HI:edgtmr_pkg::C0_CLK_LO];
	wire logic [1:0] trigger_source_select = ctrl0[edgtmr_pkg::C0_SRC_HI:edgtmr_pkg::C0_SRC_LO];
	wire logic [1:0] trigger_edge_select = ctrl1[edgtmr_pkg::C1_EDGE_HI:edgtmr_pkg::C1_EDGE_LO];
	wire logic trigger_input_enable = ctrl1[edgtmr_pkg::C1_TRIG_EN];
	wire logic filter_sample_count_select = ctrl1[edgtmr_pkg::C1_NF_CNT];
	wire logic filter_sample_clock_select = ctrl1[edgtmr_pkg::C1_NF_CLK];
	wire logic input_filter_enable = ctrl1[edgtmr_pkg::C1_NF_EN];
	wire logic clear_on_latch = ctrl1[edgtmr_pkg::C1_CLR_LATCH];
	wire logic clear_on_match = ctrl1[edgtmr_pkg::C1_CLR_MATCH];

	// ==========================================================
	// source select and filter
	logic src;
	always_comb begin
		unique case (trigger_source_select)
			2'h0: src = sensor_input_a_in;
			2'h1: src = sensor_input_b_in;
			2'h2: src = sensor_input_c_in;
			default: src = prev_in; // reserved code yields no edges
		endcase
	end

	logic nf_tick, all_same;
	always_comb begin
		nf_tick = !filter_sample_clock_select || (nf_div == edgtmr_pkg::NF_DIV);
		if (filter_sample_count_select) begin
			all_same = (hist == {4{hist[0]}});
		end else begin
			all_same = (hist[1:0] == {2{hist[0]}});
		end
	end

	// filtered level; when bypassed the raw source is used directly
	logic level, edge_ok, trig;
	always_comb begin
		level = (input_filter_enable && timer_on) ? next_filt : src;
		unique case (trigger_edge_select)
			edgtmr_pkg::EDGE_RISE: edge_ok = level && !prev_in;
			edgtmr_pkg::EDGE_FALL: edge_ok = !level && prev_in;
			edgtmr_pkg::EDGE_BOTH: edge_ok = level != prev_in;
			default: edge_ok = 1'b0;
		endcase
		trig = edge_ok && trigger_input_enable && timer_on;
	end

	// ==========================================================
	// counter clock and counter
	logic tick, match, ovf;
	always_comb begin
		if (count_clock_select == edgtmr_pkg::CLK_PWM) begin
			tick = pwm_period_tick_in;
		end else begin
			tick = (pre & ((7'h01 << (count_clock_select - 3'h1)) - 7'h01)) == 7'h00
				&& pre[count_clock_select - 3'h1];
		end
		match = timer_on && (cnt == cmp);
		ovf = timer_on && !count_pause && tick && (cnt == 16'hffff);
	end

	logic match_d, next_match_d, match_ev;
	assign match_ev = match && !match_d;

	always_comb begin
		next_on_d = timer_on;
		next_pre = timer_on ? 7'(pre + 7'h01) : 7'h00;
		next_nf_div = 2'(nf_div + 2'h1);
		next_hist = hist;
		next_filt = filt;
		if (nf_tick) begin
			next_hist = {hist[2:0], src};
		end
		if (all_same) begin
			next_filt = hist[0];
		end
		next_prev_in = level;
		next_match_d = match;
		next_cnt = cnt;
		next_cap = cap;
		if (timer_on && !on_d) begin
			next_cnt = edgtmr_pkg::RESET_WORD;
		end else if (timer_on && !count_pause) begin
			if (tick) begin
				next_cnt = 16'(cnt + 16'h0001);
			end
		end
		if (match_ev && clear_on_match) begin
			next_cnt = edgtmr_pkg::RESET_WORD;
		end
		if (trig) begin
			next_cap = cnt;
			if (clear_on_latch) begin
				next_cnt = edgtmr_pkg::RESET_WORD;
			end
		end
		next_stall = stall ? !(wr_in && addr_in == edgtmr_pkg::ADDR_INT_STATUS) : 1'b0;
		if (match_ev) begin
			next_stall = 1'b1;
		end
	end

	// ==========================================================
	// register port
	always_comb begin
		next_ctrl0 = ctrl0;
		next_ctrl1 = ctrl1;
		next_cmp = cmp;
		next_mask = mask;
		next_status = status;
		next_rdata = edgtmr_pkg::RESET_BYTE;
		if (wr_in) begin
			unique case (addr_in)
				edgtmr_pkg::ADDR_CTRL0: next_ctrl0 = wdata_in & edgtmr_pkg::C0_WMASK;
				edgtmr_pkg::ADDR_CTRL1: next_ctrl1 = wdata_in;
				edgtmr_pkg::ADDR_CMP_LOW: next_cmp[7:0] = wdata_in;
				edgtmr_pkg::ADDR_CMP_HIGH: next_cmp[15:8] = wdata_in;
				edgtmr_pkg::ADDR_INT_MASK: next_mask = wdata_in[2:0];
				default: ;
			endcase
		end
		if (rd_in) begin
			unique case (addr_in)
				edgtmr_pkg::ADDR_CTRL0: next_rdata = ctrl0;
				edgtmr_pkg::ADDR_CTRL1: next_rdata = ctrl1;
				edgtmr_pkg::ADDR_LIVE_LOW: next_rdata = cnt[7:0];
				edgtmr_pkg::ADDR_LIVE_HIGH: next_rdata = cnt[15:8];
				edgtmr_pkg::ADDR_CMP_LOW: next_rdata = cmp[7:0];
				edgtmr_pkg::ADDR_CMP_HIGH: next_rdata = cmp[15:8];
				edgtmr_pkg::ADDR_CAP_LOW: next_rdata = cap[7:0];
				edgtmr_pkg::ADDR_CAP_HIGH: next_rdata = cap[15:8];
				edgtmr_pkg::ADDR_INT_STATUS: next_rdata = {5'h00, status};
				edgtmr_pkg::ADDR_INT_MASK: next_rdata = {5'h00, mask};
				default: next_rdata = edgtmr_pkg::RESET_BYTE;
			endcase
			if (addr_in == edgtmr_pkg::ADDR_INT_STATUS) begin
				next_status = 3'h0;
			end
		end
		// set wins over the read clear
		if (ovf) begin
			next_status[edgtmr_pkg::IRQ_OVF] = 1'b1;
		end
		if (match_ev) begin
			next_status[edgtmr_pkg::IRQ_MATCH] = 1'b1;
		end
		if (trig) begin
			next_status[edgtmr_pkg::IRQ_CAPT] = 1'b1;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			ctrl0 <= edgtmr_pkg::RESET_BYTE;
			ctrl1 <= edgtmr_pkg::RESET_BYTE;
			cmp <= edgtmr_pkg::RESET_WORD;
			cnt <= edgtmr_pkg::RESET_WORD;
			status <= 3'h0;
			mask <= 3'h0;
			rdata <= edgtmr_pkg::RESET_BYTE;
			on_d <= 1'b0;
			pre <= 7'h00;
			nf_div <= 2'h0;
			hist <= 4'h0;
			filt <= 1'b0;
			prev_in <= 1'b0;
			match_d <= 1'b0;
			stall <= 1'b0;
		end else begin
			ctrl0 <= next_ctrl0;
			ctrl1 <= next_ctrl1;
			cmp <= next_cmp;
			cnt <= next_cnt;
			status <= next_status;
			mask <= next_mask;
			rdata <= next_rdata;
			on_d <= next_on_d;
			pre <= next_pre;
			nf_div <= next_nf_div;
			hist <= next_hist;
			filt <= next_filt;
			prev_in <= next_prev_in;
			match_d <= next_match_d;
			stall <= next_stall;
		end
	end

	// capture value has no reset: undefined until first capture
	always_ff @(posedge clk_sys_in) begin
		cap <= next_cap;
	end

	assign rdata_out = rdata;
	assign irq_out = |(status & mask);
	assign stall_out = stall;

	// ==========================================================
	// assertions
	sequence s_on_rise;
		!timer_on ##1 timer_on;
	endsequence
	AST_ON_CLEAR: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		s_on_rise |=> (cnt == 16'h0000 || $past(trig) || $past(match_ev))) else $error("counter not cleared on enable");
	AST_OFF_HOLD: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		!timer_on && !$past(trig) |=> $stable(cnt)) else $error("counter moved while off");
	AST_PAUSE: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		(timer_on && on_d && count_pause && !trig && !match_ev) |=> $stable(cnt)) else $error("counter moved in pause");
	AST_CAPTURE: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		trig |=> cap == $past(cnt)) else $error("capture value wrong");
	AST_CAP_CLEAR: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		trig && clear_on_latch |=> cnt == 16'h0000) else $error("no clear after capture");
	AST_MATCH_FLAG: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		match_ev |=> status[edgtmr_pkg::IRQ_MATCH] && stall_out) else $error("match flag missing");
	AST_MATCH_CLEAR: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		match_ev && clear_on_match && !trig |=> cnt == 16'h0000) else $error("no clear on match");
	AST_OVF: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		ovf |=> status[edgtmr_pkg::IRQ_OVF] && (cnt == 16'h0000)) else $error("overflow not flagged");
	AST_NO_TRIG_OFF: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		!trigger_input_enable |=> !$rose(status[edgtmr_pkg::IRQ_CAPT])) else $error("capture while disabled");
	AST_CMP_WRITE: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		wr_in && addr_in == edgtmr_pkg::ADDR_CMP_HIGH |=> cmp[15:8] == $past(wdata_in)) else $error("compare write lost");
endmodule : edgtmr_core

// [testbench/edgtmr_sensor_model.sv]
// model of the position sensors and pwm period tick that drive the edge timer
`timescale 1ns/1ps
module edgtmr_sensor_model #(
	parameter int TICK_DIV = 4
) (
	input wire logic clk_sys_in,
	input wire logic [2:0] level_in,
	input wire logic tick_en_in,
	output logic sensor_input_a_out,
	output logic sensor_input_b_out,
	output logic sensor_input_c_out,
	output logic pwm_period_tick_out
);
	int cnt = 0;
	// ==========================================================
	// pins follow the requested levels one edge later, like a real sensor
	always_ff @(posedge clk_sys_in) begin
		{sensor_input_c_out, sensor_input_b_out, sensor_input_a_out} <= level_in;
		cnt <= (cnt + 1) % TICK_DIV;
		// one-cycle tick only while enabled, so the counter can be starved on purpose
		pwm_period_tick_out <= tick_en_in && (cnt == 0);
	end
endmodule : edgtmr_sensor_model

// [testbench/tb.sv]
// self-checking testbench for the edge timer core
`timescale 1ns/1ps
module tb;
	logic clk_sys_in, rst_in, wr_in, rd_in, tick_en, sa, sb, sc, tick, irq_out, stall_out, e;
	logic [3:0] addr_in;
	logic [7:0] wdata_in, rdata_out, st;
	logic [2:0] lvl;
	logic [15:0] v, w;
	logic [3:0] ra [7] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9, 4'hf};
	int n_fail = 0;
	int checks_done = 0;
	int cyc = 0;

	edgtmr_core u_edgtmr_core (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
		.wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .sensor_input_a_in(sa), .sensor_input_b_in(sb),
		.sensor_input_c_in(sc), .pwm_period_tick_in(tick), .irq_out(irq_out), .stall_out(stall_out));
	// a tick on every cycle lets the counter reach its wrap in about 65536 cycles
	edgtmr_sensor_model #(.TICK_DIV(1)) u_edgtmr_sensor_model (.clk_sys_in(clk_sys_in), .level_in(lvl),
		.tick_en_in(tick_en), .sensor_input_a_out(sa), .sensor_input_b_out(sb), .sensor_input_c_out(sc),
		.pwm_period_tick_out(tick));

	initial begin
		clk_sys_in = 1'b0;
		forever #10 clk_sys_in = ~clk_sys_in;
	end

	// ==========================================================
	// bus tasks and comparison
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_sys_in);
		wr_in <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk_sys_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_sys_in);
		rd_in <= 1'b0;
		#1;
		d = rdata_out;
	endtask : rd
	// low then high; the pair may tear, so callers freeze the counter first, except the tick clock check, which only tests for a change
	task automatic rd16(input logic [3:0] a, output logic [15:0] d);
		rd(a, d[7:0]);
		rd(a + 4'h1, d[15:8]);
	endtask : rd16
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : stop_test

	// all tests together take about 70000 cycles, almost all of it the wait for overflow
	always @(posedge clk_sys_in) begin
		cyc++;
		if (cyc == 80000) begin
			n_fail++;
			stop_test();
		end
	end

	// ==========================================================
	// test sequence
	initial begin
		rst_in = 1'b1;
		wr_in = 1'b0;
		rd_in = 1'b0;
		addr_in = 4'h0;
		wdata_in = 8'h00;
		lvl = 3'h0;
		tick_en = 1'b0;
		repeat (3) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		foreach (ra[i]) begin
			rd(ra[i], st);
			chk(16'(st), 16'h0000);
		end
		wr(edgtmr_pkg::ADDR_CMP_LOW, 8'h34);
		wr(edgtmr_pkg::ADDR_CMP_HIGH, 8'h12);
		rd16(edgtmr_pkg::ADDR_CMP_LOW, v);
		chk(v, 16'h1234);
		$display("test registers done");
		wr(edgtmr_pkg::ADDR_CTRL0, 8'h10);
		repeat (20) @(posedge clk_sys_in);
		rd16(edgtmr_pkg::ADDR_LIVE_LOW, v);
		chk(v, 16'h0000);
		wr(edgtmr_pkg::ADDR_CTRL0, 8'h18);
		repeat (40) @(posedge clk_sys_in);
		wr(edgtmr_pkg::ADDR_CTRL0, 8'h98);
		rd16(edgtmr_pkg::ADDR_LIVE_LOW, v);
		repeat (10) @(posedge clk_sys_in);
		rd16(edgtmr_pkg::ADDR_LIVE_LOW, w);
		chk(w, v);
		chk(16'(v != 16'h0000), 16'h0001);
		wr(edgtmr_pkg::ADDR_CTRL0, 8'h90);
		rd16(edgtmr_pkg::ADDR_LIVE_LOW, w);
		chk(w, v);
		wr(edgtmr_pkg::ADDR_CTRL0, 8'h98);
		rd16(edgtmr_pkg::ADDR_LIVE_LOW, w);
		chk(w, 16'h0000);
		wr(edgtmr_pkg::ADDR_CTRL0, 8'hf8);
		wr(edgtmr_pkg::ADDR_CTRL0, 8'h78);
		repeat (256) @(posedge clk_sys_in);
		wr(edgtmr_pkg::ADDR_CTRL0, 8'hf8);
		rd16(edgtmr_pkg::ADDR_LIVE_LOW, w);
		chk(16'(w >= 16'h0002 && w <= 16'h0003), 16'h0001);
		$display("test on and pause done");
		wr(edgtmr_pkg::ADDR_CTRL0, 8'h18);
		repeat (30) @(posedge clk_sys_in);
		wr(edgtmr_pkg::ADDR_CTRL0, 8'h98);
		rd16(edgtmr_pkg::ADDR_LIVE_LOW, v);
		wr(edgtmr_pkg::ADDR_INT_MASK, 8'h07);
		for (int s = 0; s < 4; s++) begin
			for (int g = 0; g < 4; g++) begin
				wr(edgtmr_pkg::ADDR_CTRL0, 8'h98 | 8'(s));
				wr(edgtmr_pkg::ADDR_CTRL1, {2'(g), 6'h20});
				rd(edgtmr_pkg::ADDR_INT_STATUS, st);
				for (int p = 1; p >= 0; p--) begin
					lvl <= p == 0 ? 3'h0 : (s == 3 ? 3'h7 : 3'(1 << s));
					repeat (6) @(posedge clk_sys_in);
					#1;
					e = (s < 3) && (((g >> (1 - p)) & 1) == 1);
					chk(16'(irq_out), 16'(e));
					rd(edgtmr_pkg::ADDR_INT_STATUS, st);
					chk(16'(st[edgtmr_pkg::IRQ_CAPT]), 16'(e));
					if (e) begin
						rd16(edgtmr_pkg::ADDR_CAP_LOW, w);
						chk(w, v);
					end
				end
			end
		end
		wr(edgtmr_pkg::ADDR_CTRL0, 8'h98);
		wr(edgtmr_pkg::ADDR_CTRL1, 8'h40);
		lvl <= 3'h1;
		repeat (6) @(posedge clk_sys_in);
		rd(edgtmr_pkg::ADDR_INT_STATUS, st);
		chk(16'(st[edgtmr_pkg::IRQ_CAPT]), 16'h0000);
		lvl <= 3'h0;
		wr(edgtmr_pkg::ADDR_CTRL1, 8'h62);
		lvl <= 3'h1;
		repeat (6) @(posedge clk_sys_in);
		rd16(edgtmr_pkg::ADDR_LIVE_LOW, w);
		chk(w, 16'h0000);
		lvl <= 3'h0;
		$display("test capture done");
		wr(edgtmr_pkg::ADDR_CTRL1, 8'h74);
		repeat (6) @(posedge clk_sys_in);
		rd(edgtmr_pkg::ADDR_INT_STATUS, st);
		lvl <= 3'h1;
		repeat (2) @(posedge clk_sys_in);
		lvl <= 3'h0;
		repeat (8) @(posedge clk_sys_in);
		rd(edgtmr_pkg::ADDR_INT_STATUS, st);
		chk(16'(st[edgtmr_pkg::IRQ_CAPT]), 16'h0000);
		lvl <= 3'h1;
		repeat (10) @(posedge clk_sys_in);
		rd(edgtmr_pkg::ADDR_INT_STATUS, st);
		chk(16'(st[edgtmr_pkg::IRQ_CAPT]), 16'h0001);
		lvl <= 3'h0;
		$display("test filter done");
		wr(edgtmr_pkg::ADDR_CMP_LOW, 8'h40);
		wr(edgtmr_pkg::ADDR_CMP_HIGH, 8'h00);
		wr(edgtmr_pkg::ADDR_CTRL1, 8'h01);
		rd(edgtmr_pkg::ADDR_INT_STATUS, st);
		wr(edgtmr_pkg::ADDR_CTRL0, 8'h18);
		for (int i = 0; i < 300 && stall_out !== 1'b1; i++) @(posedge clk_sys_in);
		#1;
		chk(16'(stall_out), 16'h0001);
		chk(16'(irq_out), 16'h0001);
		rd(edgtmr_pkg::ADDR_INT_STATUS, st);
		chk(16'(st[edgtmr_pkg::IRQ_MATCH]), 16'h0001);
		repeat (200) @(posedge clk_sys_in);
		wr(edgtmr_pkg::ADDR_CTRL0, 8'h98);
		rd16(edgtmr_pkg::ADDR_LIVE_LOW, w);
		chk(16'(w < 16'h0041), 16'h0001);
		wr(edgtmr_pkg::ADDR_INT_STATUS, 8'h00);
		repeat (2) @(posedge clk_sys_in);
		chk(16'(stall_out), 16'h0000);
		$display("test compare done");
		wr(edgtmr_pkg::ADDR_CTRL1, 8'h00);
		wr(edgtmr_pkg::ADDR_CTRL0, 8'h08);
		rd16(edgtmr_pkg::ADDR_LIVE_LOW, v);
		repeat (20) @(posedge clk_sys_in);
		rd16(edgtmr_pkg::ADDR_LIVE_LOW, w);
		chk(w, v);
		tick_en <= 1'b1;
		repeat (100) @(posedge clk_sys_in);
		rd16(edgtmr_pkg::ADDR_LIVE_LOW, w);
		chk(16'(w != v), 16'h0001);
		$display("test tick clock done");
		wr(edgtmr_pkg::ADDR_INT_MASK, 8'h01);
		rd(edgtmr_pkg::ADDR_INT_STATUS, st);
		for (int i = 0; i < 66000 && irq_out !== 1'b1; i++) @(posedge clk_sys_in);
		#1;
		chk(16'(irq_out), 16'h0001);
		wr(edgtmr_pkg::ADDR_CTRL0, 8'h88);
		rd16(edgtmr_pkg::ADDR_LIVE_LOW, w);
		chk(16'(w < 16'h0010), 16'h0001);
		rd(edgtmr_pkg::ADDR_INT_STATUS, st);
		chk(16'(st[edgtmr_pkg::IRQ_OVF]), 16'h0001);
		$display("test overflow done");
		stop_test();
	end
endmodule : tb
